// file: pkg/uvcalc_pkg.sv
// package for the user variable calculation and interrupt return unit
// assumes a 32-bit signed data path and 8-bit command fields
package uvcalc_pkg;
   localparam logic [7:0] INSTR_RETURN_FROM_INTERRUPT = 8'h26;
   localparam logic [7:0] INSTR_CALC_VAR_VAR = 8'h28;
   localparam logic [7:0] INSTR_CALC_VAR_WITH_ACCUMULATOR = 8'h29;
   localparam logic [7:0] STATUS_OK = 8'h64;
   localparam logic [7:0] STATUS_BAD_COMMAND = 8'h02;
   localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
   localparam logic [7:0] HOST_ADDRESS_RESET = 8'h02;
   localparam logic [7:0] TARGET_ADDRESS_RESET = 8'h01;
   localparam logic [31:0] WORD_RESET = 32'h00000000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam int FLAG_ZERO = 0;
   localparam int FLAG_NEG = 1;
   localparam int FLAG_EQUAL = 2;
   localparam int FLAG_GREATER = 3;
   localparam int FLAG_LESS = 4;
   localparam int FLAG_DIVZERO = 5;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   typedef enum logic [3:0] {
      OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MOD, OP_AND, OP_OR, OP_XOR,
      OP_NOT, OP_LOAD, OP_SWAP, OP_COMP, OP_BAD4, OP_BAD5, OP_BAD6, OP_BAD7
   } uvcalc_op_t;
endpackage

// file: src/uvcalc_unit.sv
// command execution unit: return from interrupt, calc_var_var, calc_var_with_accumulator
// assumes commands arrive already framed and checksum-checked, one per cmdValid pulse
// Function
// R1: interrupt return restores saved working registers
// R2: interrupt return ends handler, resumes program
// R3: program ends handlers with interrupt return
// R4: successful command replies status 100
// R5: two-variable op writes result to first
// R6: type=op, motor/bank=var1, value=var2
// R7: codes 0-7: arithmetic and logic ops
// R8: 8 not, 9 copy, 10 swap, 11 compare
// R9: two-variable op spares accumulator and X
// R10: accumulator op modifies indexed variable only, except 10 which also writes the accumulator
// R11: codes 0-7 combine accumulator into variable
// R12: 8 inverted accumulator, 9 accumulator copy
// R13: 10 exchange with accumulator, 11 compare
// R14: compare keeps operands, sets condition flags
// R15: host frame fields, value msb first
// R16: reply frame fields, value msb first
`timescale 1ns/10ps
module uvcalc_unit #(
   parameter int NUM_VARS = 256
) (
   input wire logic clock, // 100 MHz
   input wire logic rst_n, // synchronous reset, active low
   input wire logic cmdValid, // one-cycle command strobe
   input wire logic [7:0] cmdTarget, // target address
   input wire logic [7:0] cmdInstr, // instruction number
   input wire logic [7:0] cmdType, // type field
   input wire logic [7:0] cmdBank, // motor/bank field
   input wire logic [31:0] cmdValue, // value, byte 3 in bits 31:24
   input wire logic irqEnter, // interrupt entry: save and jump
   input wire logic [15:0] irqVector, // handler address
   input wire logic [31:0] accIn, // accumulator value from program engine
   input wire logic accLoad, // load accIn into accumulator
   input wire logic [15:0] pcIn, // program counter from program engine
   input wire logic pcLoad, // load pcIn into program counter
   output logic replyValid, // one-cycle reply strobe
   output logic [7:0] replyHost, // host address
   output logic [7:0] replyTarget, // target address
   output logic [7:0] replyStatus, // status
   output logic [7:0] replyInstr, // instruction echoed
   output logic [31:0] replyValue, // value, byte 3 in bits 31:24
   output logic [31:0] accumulator, // accumulator
   output logic [31:0] xReg, // X register
   output logic [7:0] flags, // condition flags
   output logic [15:0] progCounter, // program counter
   output logic inHandler // interrupt handler active
);
   logic [31:0] userVars [NUM_VARS];
   logic [31:0] savedAcc;
   logic [31:0] savedX;
   logic [7:0] savedFlags;
   logic [15:0] savedPc;
   logic isReturn;
   logic isVarVar;
   logic isVarAcc;
   logic opLegal;
   logic cmdOk;
   uvcalc_pkg::uvcalc_op_t op;
   logic [31:0] opA;
   logic [31:0] opB;
   logic [31:0] next_result;
   logic [7:0] next_flags;
   logic [63:0] product;
   logic divZero;

   assign isReturn = cmdInstr == uvcalc_pkg::INSTR_RETURN_FROM_INTERRUPT;
   assign isVarVar = cmdInstr == uvcalc_pkg::INSTR_CALC_VAR_VAR;
   assign isVarAcc = cmdInstr == uvcalc_pkg::INSTR_CALC_VAR_WITH_ACCUMULATOR;
   assign op = uvcalc_pkg::uvcalc_op_t'(cmdType[3:0]);
   assign opLegal = cmdType <= 8'(uvcalc_pkg::OP_COMP);
   assign cmdOk = isReturn || ((isVarVar || isVarAcc) && opLegal);

   // operand selection
   always_comb begin
      opA = userVars[cmdBank]; // R6
      if (isVarVar) begin
         opB = userVars[cmdValue[7:0]]; // R6 R9
      end else begin
         opB = accumulator; // R10
      end
   end

   assign product = $signed(opA) * $signed(opB);
   assign divZero = opB == uvcalc_pkg::WORD_RESET;

   // operation decode; division by zero leaves the variable as it was
   always_comb begin
      next_result = opA;
      next_flags = flags;
      case (op)
         uvcalc_pkg::OP_ADD: next_result = opA + opB; // R7 R11
         uvcalc_pkg::OP_SUB: next_result = opA - opB; // R7 R11
         uvcalc_pkg::OP_MUL: next_result = product[31:0]; // R7 R11
         uvcalc_pkg::OP_DIV: begin
            if (!divZero) begin
               next_result = $signed(opA) / $signed(opB); // R7 R11
            end
         end
         uvcalc_pkg::OP_MOD: begin
            if (!divZero) begin
               next_result = $signed(opA) % $signed(opB); // R7 R11
            end
         end
         uvcalc_pkg::OP_AND: next_result = opA & opB; // R7 R11
         uvcalc_pkg::OP_OR: next_result = opA | opB; // R7 R11
         uvcalc_pkg::OP_XOR: next_result = opA ^ opB; // R7 R11
         uvcalc_pkg::OP_NOT: next_result = ~opB; // R8 R12
         uvcalc_pkg::OP_LOAD: next_result = opB; // R8 R12
         uvcalc_pkg::OP_SWAP: next_result = opB; // R8 R13
         uvcalc_pkg::OP_COMP: begin
            next_flags[uvcalc_pkg::FLAG_EQUAL] = opA == opB; // R14
            next_flags[uvcalc_pkg::FLAG_GREATER] = $signed(opA) > $signed(opB); // R14
            next_flags[uvcalc_pkg::FLAG_LESS] = $signed(opA) < $signed(opB); // R14
         end
         default: next_result = opA;
      endcase
      if (op != uvcalc_pkg::OP_COMP) begin
         next_flags[uvcalc_pkg::FLAG_ZERO] = next_result == uvcalc_pkg::WORD_RESET;
         next_flags[uvcalc_pkg::FLAG_NEG] = next_result[31];
      end
      next_flags[uvcalc_pkg::FLAG_DIVZERO] =
         divZero && (op == uvcalc_pkg::OP_DIV || op == uvcalc_pkg::OP_MOD);
   end

   // user variable file
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_VARS; i++) begin
            userVars[i] <= uvcalc_pkg::WORD_RESET;
         end
      end else if (cmdValid && (isVarVar || isVarAcc) && opLegal &&
                   op != uvcalc_pkg::OP_COMP) begin
         userVars[cmdBank] <= next_result; // R5 R10
         if (isVarVar && op == uvcalc_pkg::OP_SWAP) begin
            userVars[cmdValue[7:0]] <= opA; // R8
         end
      end
   end

   // accumulator: restored on interrupt return, set by the variable-and-accumulator swap, else loaded from accIn
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         accumulator <= uvcalc_pkg::WORD_RESET;
      end else if (cmdValid && isReturn && inHandler) begin
         accumulator <= savedAcc; // R1
      end else if (cmdValid && isVarAcc && opLegal && op == uvcalc_pkg::OP_SWAP) begin
         accumulator <= opA; // R13
      end else if (accLoad) begin
         accumulator <= accIn;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         xReg <= uvcalc_pkg::WORD_RESET;
      end else if (cmdValid && isReturn && inHandler) begin
         xReg <= savedX; // R1
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         flags <= uvcalc_pkg::FLAGS_RESET;
      end else if (cmdValid && isReturn && inHandler) begin
         flags <= savedFlags; // R1
      end else if (cmdValid && (isVarVar || isVarAcc) && opLegal) begin
         flags <= next_flags; // R14
      end
   end

   // program counter and interrupt context
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         progCounter <= uvcalc_pkg::PC_RESET;
         inHandler <= 1'b0;
         savedAcc <= uvcalc_pkg::WORD_RESET;
         savedX <= uvcalc_pkg::WORD_RESET;
         savedFlags <= uvcalc_pkg::FLAGS_RESET;
         savedPc <= uvcalc_pkg::PC_RESET;
      end else if (cmdValid && isReturn && inHandler) begin
         progCounter <= savedPc; // R1 R2
         inHandler <= 1'b0; // R2
      end else if (irqEnter && !inHandler && !(cmdValid && isReturn)) begin // R1
         savedAcc <= accumulator;
         savedX <= xReg;
         savedFlags <= flags;
         savedPc <= progCounter;
         progCounter <= irqVector;
         inHandler <= 1'b1;
      end else if (pcLoad) begin
         progCounter <= pcIn;
      end
   end

   // reply frame
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         replyValid <= 1'b0;
         replyHost <= uvcalc_pkg::HOST_ADDRESS_RESET;
         replyTarget <= uvcalc_pkg::TARGET_ADDRESS_RESET;
         replyStatus <= uvcalc_pkg::STATUS_OK;
         replyInstr <= 8'h00;
         replyValue <= uvcalc_pkg::WORD_RESET;
      end else begin
         replyValid <= cmdValid; // R16
         if (cmdValid) begin
            replyTarget <= cmdTarget; // R16
            replyInstr <= cmdInstr; // R16
            replyValue <= isReturn ? uvcalc_pkg::WORD_RESET : opB; // R4
            if (cmdOk) begin
               replyStatus <= uvcalc_pkg::STATUS_OK; // R4
            end else if (isVarVar || isVarAcc) begin
               replyStatus <= uvcalc_pkg::STATUS_BAD_TYPE;
            end else begin
               replyStatus <= uvcalc_pkg::STATUS_BAD_COMMAND;
            end
         end
      end
   end

   // checks
   // interrupt context moves in two steps: saved on entry, copied back on return
   sequence s_irq_taken;
      irqEnter && !inHandler && !(cmdValid && isReturn);
   endsequence
   sequence s_return_taken;
      cmdValid && isReturn && inHandler;
   endsequence
   a_reply_follows_cmd: assert property (@(posedge clock) disable iff (!rst_n) // R16
      cmdValid |=> replyValid) else $error("reply missing");
   a_reply_quiet: assert property (@(posedge clock) disable iff (!rst_n) // R16
      !cmdValid |=> !replyValid) else $error("reply without command");
   a_reply_echo: assert property (@(posedge clock) disable iff (!rst_n) // R16
      cmdValid |=> replyInstr == $past(cmdInstr) && replyTarget == $past(cmdTarget))
      else $error("reply fields not echoed");
   a_status_ok: assert property (@(posedge clock) disable iff (!rst_n) // R4
      cmdValid && cmdOk |=> replyStatus == uvcalc_pkg::STATUS_OK)
      else $error("status not ok");
   a_bad_type: assert property (@(posedge clock) disable iff (!rst_n) // R4
      cmdValid && (isVarVar || isVarAcc) && !opLegal && !accLoad |=>
      replyStatus == uvcalc_pkg::STATUS_BAD_TYPE && $stable(flags) && $stable(accumulator))
      else $error("refused type changed state");
   a_bad_instr: assert property (@(posedge clock) disable iff (!rst_n) // R4
      cmdValid && !isReturn && !isVarVar && !isVarAcc |=>
      replyStatus == uvcalc_pkg::STATUS_BAD_COMMAND) else $error("unknown instruction accepted");
   a_irq_saves: assert property (@(posedge clock) disable iff (!rst_n) // R1
      s_irq_taken |=> inHandler && progCounter == $past(irqVector) &&
      savedPc == $past(progCounter) && savedAcc == $past(accumulator) &&
      savedX == $past(xReg) && savedFlags == $past(flags)) else $error("entry not saved");
   a_return_restores: assert property (@(posedge clock) disable iff (!rst_n) // R1
      s_return_taken |=> progCounter == $past(savedPc) && accumulator == $past(savedAcc) &&
      flags == $past(savedFlags) && xReg == $past(savedX)) else
      $error("return did not restore");
   a_return_ends: assert property (@(posedge clock) disable iff (!rst_n) // R2
      cmdValid && isReturn |=> !inHandler) else $error("handler still active");
   a_return_idle: assert property (@(posedge clock) disable iff (!rst_n) // R2
      cmdValid && isReturn && !inHandler && !pcLoad && !accLoad |=>
      $stable(progCounter) && $stable(accumulator)) else $error("idle return moved state");
   a_vv_spares_acc: assert property (@(posedge clock) disable iff (!rst_n) // R9
      cmdValid && isVarVar && !accLoad && !inHandler |=> $stable(accumulator) && $stable(xReg))
      else $error("accumulator touched");
   a_vv_add: assert property (@(posedge clock) disable iff (!rst_n) // R5
      cmdValid && isVarVar && cmdType == 8'h00 && cmdBank != cmdValue[7:0] |=>
      userVars[$past(cmdBank)] == $past(opA) + $past(opB)) else $error("add wrong");
   a_vv_mul: assert property (@(posedge clock) disable iff (!rst_n) // R7
      cmdValid && isVarVar && cmdType == 8'h02 |=>
      userVars[$past(cmdBank)] == $past(opA) * $past(opB)) else $error("multiply wrong");
   a_vv_second_kept: assert property (@(posedge clock) disable iff (!rst_n) // R5
      cmdValid && isVarVar && opLegal && cmdType != 8'h0a && cmdBank != cmdValue[7:0] |=>
      userVars[$past(cmdValue[7:0])] == $past(opB)) else $error("second variable changed");
   a_vv_swap: assert property (@(posedge clock) disable iff (!rst_n) // R8
      cmdValid && isVarVar && cmdType == 8'h0a |=> userVars[$past(cmdBank)] == $past(opB) &&
      userVars[$past(cmdValue[7:0])] == $past(opA)) else $error("variable swap wrong");
   a_vv_not: assert property (@(posedge clock) disable iff (!rst_n) // R8
      cmdValid && isVarVar && cmdType == 8'h08 |=> userVars[$past(cmdBank)] == ~$past(opB))
      else $error("variable invert wrong");
   a_vv_compare: assert property (@(posedge clock) disable iff (!rst_n) // R14
      cmdValid && isVarVar && cmdType == 8'h0b |=> userVars[$past(cmdBank)] == $past(opA) &&
      flags[uvcalc_pkg::FLAG_GREATER] == ($signed($past(opA)) > $signed($past(opB))))
      else $error("variable compare wrong");
   a_div_zero: assert property (@(posedge clock) disable iff (!rst_n) // R7
      cmdValid && (isVarVar || isVarAcc) && cmdType == 8'h03 && divZero |=>
      userVars[$past(cmdBank)] == $past(opA) && flags[uvcalc_pkg::FLAG_DIVZERO])
      else $error("divide by zero changed variable");
   a_va_acc_kept: assert property (@(posedge clock) disable iff (!rst_n) // R10
      cmdValid && isVarAcc && cmdType != 8'h0a && !accLoad |=> $stable(accumulator))
      else $error("accumulator changed");
   a_va_sub: assert property (@(posedge clock) disable iff (!rst_n) // R11
      cmdValid && isVarAcc && cmdType == 8'h01 |=>
      userVars[$past(cmdBank)] == $past(opA) - $past(opB)) else $error("subtract wrong");
   a_va_or: assert property (@(posedge clock) disable iff (!rst_n) // R11
      cmdValid && isVarAcc && cmdType == 8'h06 |=>
      userVars[$past(cmdBank)] == ($past(opA) | $past(opB))) else $error("or wrong");
   a_va_load: assert property (@(posedge clock) disable iff (!rst_n) // R12
      cmdValid && isVarAcc && cmdType == 8'h09 |=>
      userVars[$past(cmdBank)] == $past(accumulator)) else $error("load wrong");
   a_va_swap: assert property (@(posedge clock) disable iff (!rst_n) // R13
      cmdValid && isVarAcc && cmdType == 8'h0a |=> accumulator == $past(opA) &&
      userVars[$past(cmdBank)] == $past(opB)) else $error("swap wrong");
   a_comp_keeps: assert property (@(posedge clock) disable iff (!rst_n) // R14
      cmdValid && isVarAcc && cmdType == 8'h0b |=> userVars[$past(cmdBank)] == $past(opA) &&
      flags[uvcalc_pkg::FLAG_EQUAL] == ($past(opA) == $past(opB))) else
      $error("compare wrong");
   a_va_not: assert property (@(posedge clock) disable iff (!rst_n) // R12
      cmdValid && isVarAcc && cmdType == 8'h08 |=> userVars[$past(cmdBank)] == ~$past(opB))
      else $error("not wrong");
endmodule

// file: testbench/user_variable_calc_irq_return_tb_top.sv
// bench for the calculation and interrupt return unit
// assumes the unit answers one cycle after each command
`timescale 1ns/10ps
module user_variable_calc_irq_return_tb_top;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cmdValid, replyValid, inHandler;
   logic accLoad = 1'b0, pcLoad = 1'b0, irqEnter = 1'b0;
   logic [7:0] cmdTarget, cmdInstr, cmdType, cmdBank, replyHost, replyTarget;
   logic [7:0] replyStatus, replyInstr, flags;
   logic [31:0] cmdValue, replyValue, accumulator, xReg, r;
   logic [31:0] accIn = '0;
   logic [15:0] pcIn = '0, irqVector = '0, progCounter;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   localparam logic [7:0] OK = uvcalc_pkg::STATUS_OK;
   always #5 clock = ~clock;
   uvcalc_host uvcalc_host_i (.clock(clock), .cmdValid(cmdValid), .cmdTarget(cmdTarget),
      .cmdInstr(cmdInstr), .cmdType(cmdType), .cmdBank(cmdBank), .cmdValue(cmdValue));
   uvcalc_unit #(.NUM_VARS(256)) uvcalc_unit_i (.clock(clock), .rst_n(rst_n),
      .cmdValid(cmdValid), .cmdTarget(cmdTarget), .cmdInstr(cmdInstr), .cmdType(cmdType),
      .cmdBank(cmdBank), .cmdValue(cmdValue), .irqEnter(irqEnter), .irqVector(irqVector),
      .accIn(accIn), .accLoad(accLoad), .pcIn(pcIn), .pcLoad(pcLoad),
      .replyValid(replyValid), .replyHost(replyHost), .replyTarget(replyTarget),
      .replyStatus(replyStatus), .replyInstr(replyInstr), .replyValue(replyValue),
      .accumulator(accumulator), .xReg(xReg), .flags(flags), .progCounter(progCounter),
      .inHandler(inHandler));
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   function automatic logic [31:0] calc(input int op, input logic [31:0] a, b);
      case (op)
         0: return a + b;
         1: return a - b;
         2: return a * b;
         3: return $signed(a) / $signed(b);
         4: return $signed(a) % $signed(b);
         5: return a & b;
         6: return a | b;
         7: return a ^ b;
         8: return ~b;
         9: return b;
         10: return b;
         default: return a;
      endcase
   endfunction
   task automatic cmd(input logic [7:0] i, t, b, input logic [31:0] v, input logic [7:0] s);
      uvcalc_host_i.send(i, t, b, v);
      chk("replyValid", 1, replyValid);
      chk("replyStatus", s, replyStatus);
      chk("replyInstr", i, replyInstr);
      chk("replyTarget", 8'h01, replyTarget);
   endtask
   task automatic pulse(input int k);
      @(posedge clock);
      #1;
      {accLoad, pcLoad, irqEnter} = 3'(k);
      @(posedge clock);
      #1;
      {accLoad, pcLoad, irqEnter} = 3'h0;
   endtask
   task automatic setAcc(input logic [31:0] v);
      accIn = v;
      pulse(4);
   endtask
   task automatic wrVar(input logic [7:0] k, input logic [31:0] v);
      setAcc(v);
      cmd(8'h29, 8'h09, k, 0, OK);
   endtask
   task automatic rdVar(input logic [7:0] k);
      cmd(8'h28, 8'h0b, k, {24'h0, k}, OK);
      r = replyValue;
   endtask
   task automatic test_ops();
      for (int op = 0; op < 12; op++) begin
         wrVar(8'hff, 100);
         wrVar(8'h00, 7);
         setAcc(32'habc);
         cmd(8'h28, 8'(op), 8'hff, 0, OK);
         chk("vvOperand", 7, replyValue);
         chk("vvAcc", 32'habc, accumulator);
         chk("vvX", 0, xReg);
         if (op == 11) chk("vvCmp", 3'b010, {flags[4], flags[3], flags[2]});
         rdVar(8'hff);
         chk("vvResult", calc(op, 100, 7), r);
         rdVar(8'h00);
         chk("vvSecond", (op == 10) ? 100 : 7, r);
         wrVar(8'h03, 100);
         setAcc(7);
         cmd(8'h29, 8'(op), 8'h03, 32'hffffffff, OK);
         chk("vaAcc", (op == 10) ? 100 : 7, accumulator);
         rdVar(8'h03);
         chk("vaResult", calc(op, 100, 7), r);
      end
      $display("test ops done");
   endtask
   task automatic test_irq();
      setAcc(5);
      pcIn = 16'h1234;
      pulse(2);
      irqVector = 16'h0040;
      pulse(1);
      chk("handler", 1, inHandler);
      chk("vector", 16'h0040, progCounter);
      setAcc(9);
      cmd(8'h28, 8'h0b, 8'hff, 0, OK);
      chk("handlerFlags", 8'h08, flags);
      cmd(8'h26, 8'hff, 0, 0, OK);
      chk("accBack", 5, accumulator);
      chk("flagsBack", 8'h04, flags);
      chk("xBack", 0, xReg);
      chk("pcBack", 16'h1234, progCounter);
      chk("handlerEnd", 0, inHandler);
      cmd(8'h26, 8'hff, 0, 0, OK);
      chk("pcStays", 16'h1234, progCounter);
      cmd(8'h28, 8'h0c, 1, 2, uvcalc_pkg::STATUS_BAD_TYPE);
      cmd(8'h2b, 8'h00, 1, 2, uvcalc_pkg::STATUS_BAD_COMMAND);
      wrVar(8'h05, 9);
      setAcc(0);
      cmd(8'h29, 8'h03, 8'h05, 0, OK);
      chk("divFlag", 1, flags[uvcalc_pkg::FLAG_DIVZERO]);
      rdVar(8'h05);
      chk("divKeeps", 9, r);
      $display("test irq done");
   endtask
   initial begin
      repeat (16) @(posedge clock);
      #1;
      rst_n = 1'b1;
      chk("replyHost", 8'h02, replyHost);
      chk("replyTarget", 8'h01, replyTarget);
      test_ops();
      test_irq();
      results();
   end
endmodule

// file: testbench/uvcalc_host.sv
// host model: sends one command frame per call
// assumes the unit takes a frame at the edge where cmdValid is high
`timescale 1ns/10ps
module uvcalc_host (
   input wire logic clock, // bench clock
   output logic cmdValid, // command strobe
   output logic [7:0] cmdTarget, // target address
   output logic [7:0] cmdInstr, // instruction number
   output logic [7:0] cmdType, // type field
   output logic [7:0] cmdBank, // motor/bank field
   output logic [31:0] cmdValue // value, msb byte in 31:24
);
   initial begin
      cmdValid = 1'b0;
      {cmdTarget, cmdInstr, cmdType, cmdBank, cmdValue} = '0;
   end
   task automatic send(input logic [7:0] i, input logic [7:0] t, input logic [7:0] b,
         input logic [31:0] v);
      @(posedge clock);
      #1;
      {cmdTarget, cmdInstr, cmdType, cmdBank, cmdValue} = {8'h01, i, t, b, v};
      cmdValid = 1'b1;
      @(posedge clock);
      #1;
      cmdValid = 1'b0;
      // idle fields carry no meaning, so show them inverted
      {cmdTarget, cmdInstr, cmdType, cmdBank, cmdValue} =
         ~{cmdTarget, cmdInstr, cmdType, cmdBank, cmdValue};
   endtask
endmodule
